//--- panel_bus_defs.vh
`ifndef PANEL_BUS_DEFS_VH
`define PANEL_BUS_DEFS_VH

// bus mode codes on mode_in
`define MODE_W 3
`define MODE_ASYNC_EN 3'h0
`define MODE_ASYNC_SPLIT 3'h1
`define MODE_SYNC_EN 3'h2
`define MODE_SYNC_SPLIT 3'h3
`define MODE_PER_DEVICE 3'h4

// shared address/data bus
`define BUS_W 16

// timing word per chip select: setup, strobe, hold in bus clock ticks
`define TIM_W 12
`define PHASE_W 4
`define TIM_SETUP_LSB 0
`define TIM_STROBE_LSB 4
`define TIM_HOLD_LSB 8

// transaction kinds
`define KIND_W 2
`define KIND_ADDR_WR 2'h0
`define KIND_DATA_WR 2'h1
`define KIND_DATA_RD 2'h2
`define KIND_STATUS_RD 2'h3

// chip select indices
`define CS_0 1'h0
`define CS_1 1'h1

// highest internal bus clock rate, kHz
`define BUS_CLK_MAX_KHZ 42000

// data buffer depth
`define BUF_DEPTH 2
`define BUF_CNT_W 2

`endif

//--- bus_clock_sampler.v
`timescale 1ns/100ps
// brings the internal bus clock into the ref clock domain and marks its rising edges
module bus_clock_sampler (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // raw bus clock from outside the domain
  input wire bus_clk_in,
  // synchronised level and one-cycle rising edge pulse
  output reg level_out,
  output reg rise_out
);

  reg meta_q;
  reg sync_q;

  // two-flop synchroniser; the edge logic compares sync_q with its one-cycle delayed copy level_out
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      meta_q <= bus_clk_in;
      sync_q <= meta_q;
      level_out <= sync_q;
      rise_out <= sync_q & ~level_out;
    end
  end

endmodule // bus_clock_sampler

//--- word_buffer2.v
`timescale 1ns/100ps
`include "panel_bus_defs.vh"
// two-entry buffer; a stalled reader never drops a word
module word_buffer2 #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // filling side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output reg in_ready_out,
  // draining side
  output wire out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);

  reg [WIDTH-1:0] mem_q [0:`BUF_DEPTH-1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [`BUF_CNT_W-1:0] cnt_q;
  reg [`BUF_CNT_W-1:0] cnt_d;
  wire push;
  wire pop;

  assign out_valid_out = (cnt_q != {`BUF_CNT_W{1'b0}});
  assign out_data_out = mem_q[rd_ptr_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // occupancy after this cycle's push and pop
  always @* begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  // ready is registered so the port comes from a flop
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= {`BUF_CNT_W{1'b0}};
      in_ready_out <= 1'b0;
    end else begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= cnt_d;
      in_ready_out <= (cnt_d != `BUF_DEPTH);
    end
  end

  // storage has no reset; valid gates every read of it
  always @(posedge ref_clk_in) begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_in;
  end

endmodule // word_buffer2

//--- lcd_character_panel_bus_master.v
`timescale 1ns/100ps
`include "panel_bus_defs.vh"
// Notes on behaviour
// RQ1 - asynchronous modes serve two chip selects, each with its own timing, same strobe style
// RQ2 - synchronous modes serve only chip select 0, with programmable timing
// RQ3 - generic 16-bit interleaved address/data master, no stall input from outside
// RQ4 - dma transfers are data writes only, sourced from frame buffer 0
// RQ5 - cpu issues data cycles and command/address cycles through the ports
// RQ6 - internal bus clock may run up to 42 MHz
// RQ7 - pixel-clock and hsync pins become strobe/direction or read/write strobe by mode
// RQ8 - vsync carries latch enable; ac-bias and memory-clock pins carry selects or enables
// RQ9 - per-device mode holds latch enable low for commands; address port write starts one
// RQ10 - per-device mode: direction selects read or write, enable 0 strobes device 0
// RQ11 - per-device read data must be valid the bus cycle before enable 0 drops
// RQ12 - address goes out first, latched outside, then data completes the transaction
// RQ13 - enable modes: direction high for reads, low for writes incl. address latch write
// RQ14 - cpu write to address port drives the address with latch enable high
// RQ15 - cpu write to data port is a data cycle, latch enable low, strobe pulsed
// RQ16 - chip select 0 is active through both address and data cycles
// RQ17 - cpu read of data port starts data read, latch enable low, direction high
// RQ18 - enable modes: read data valid the bus cycle before the strobe drops
// RQ19 - cpu read of address port is status read: no address, latch enable high, strobe
// RQ20 - data buffer enable low while write data is on the bus, high otherwise
// RQ21 - split modes: write strobe clocks write data in during the data cycle
// RQ22 - split modes: read data valid the bus cycle before the read strobe drops
// RQ23 - split modes status read: latch enable, chip select 0, read strobe pulsed
// RQ24 - cpu read completes only after sampled data is in the returned register
// RQ25 - synchronous modes: every bus output moves with the driven memory clock
module lcd_character_panel_bus_master (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // configuration
  input wire [`MODE_W-1:0] mode_in,
  input wire [`TIM_W-1:0] cs0_timing_in,
  input wire [`TIM_W-1:0] cs1_timing_in,
  // internal bus clock source
  input wire bus_clk_in,
  // cpu port access
  input wire cpu_req_in,
  input wire cpu_write_in,
  input wire cpu_addr_port_in,
  input wire cpu_cs_in,
  input wire [`BUS_W-1:0] cpu_wdata_in,
  output reg cpu_ack_out,
  output reg [`BUS_W-1:0] cpu_rdata_out,
  // dma data stream from frame buffer 0
  input wire dma_enable_in,
  input wire dma_valid_in,
  input wire [`BUS_W-1:0] dma_data_in,
  output wire dma_ready_out,
  // status
  output reg busy_out,
  // panel pins
  output reg pclk_pin_out,
  output reg hsync_pin_out,
  output reg vsync_pin_out,
  output reg ac_bias_pin_out,
  output reg memory_clk_pin_out,
  output reg data_buffer_out_en_n_out,
  // shared address/data bus, two-way
  input wire [`BUS_W-1:0] data_in,
  output reg [`BUS_W-1:0] data_out,
  output reg data_oe_n_out
);

  localparam ST_IDLE = 4'h1;
  localparam ST_SETUP = 4'h2;
  localparam ST_STROBE = 4'h4;
  localparam ST_HOLD = 4'h8;

  // mode decoding used by the engine and by the pin mapping
  function is_sync;
    input [`MODE_W-1:0] m;
    begin
      is_sync = (m == `MODE_SYNC_EN) || (m == `MODE_SYNC_SPLIT);
    end
  endfunction

  function is_split;
    input [`MODE_W-1:0] m;
    begin
      is_split = (m == `MODE_ASYNC_SPLIT) || (m == `MODE_SYNC_SPLIT);
    end
  endfunction

  function is_pde;
    input [`MODE_W-1:0] m;
    begin
      is_pde = (m == `MODE_PER_DEVICE);
    end
  endfunction

  // picks one phase length out of a timing word
  function [`PHASE_W-1:0] phase_len;
    input [`TIM_W-1:0] tim;
    input integer lsb;
    begin
      phase_len = tim[lsb +: `PHASE_W];
    end
  endfunction

  reg [3:0] state_q;
  reg [`PHASE_W-1:0] cnt_q;
  reg [`KIND_W-1:0] kind_q;
  reg cs_q;
  reg from_cpu_q;
  reg [`MODE_W-1:0] mode_q;
  reg [`TIM_W-1:0] tim_q;
  reg [`BUS_W-1:0] wdata_q;
  reg [`BUS_W-1:0] din_meta_q;
  reg [`BUS_W-1:0] din_sync_q;
  wire bus_level;
  wire bus_tick;
  wire buf_valid;
  wire [`BUS_W-1:0] buf_data;
  wire buf_take;
  wire cpu_take;
  wire phase_end;
  wire [`TIM_W-1:0] cpu_tim;
  wire cpu_cs_eff;

  // bus clock edges pace every phase; at 100 MHz sampling the usable rate sits well below
  // the 42 MHz ceiling, which only a faster reference would reach [RQ6]
  bus_clock_sampler u_bus_clk (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .bus_clk_in(bus_clk_in),
    .level_out(bus_level),
    .rise_out(bus_tick)
  );

  // dma words wait here while a cpu cycle or a slow bus holds the engine
  word_buffer2 #(
    .WIDTH(`BUS_W)
  ) u_dma_buf (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .in_valid_in(dma_valid_in),
    .in_data_in(dma_data_in),
    .in_ready_out(dma_ready_out),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(buf_take)
  );

  // synchronous modes reach only chip select 0 [RQ2]
  assign cpu_cs_eff = is_sync(mode_in) ? `CS_0 : cpu_cs_in;
  // each chip select carries its own timing [RQ1]
  assign cpu_tim = (cpu_cs_eff == `CS_1) ? cs1_timing_in : cs0_timing_in;
  // the cpu wins arbitration; a cycle starts only on a bus clock edge [RQ5] [RQ25]
  assign cpu_take = bus_tick && (state_q == ST_IDLE) && cpu_req_in && !cpu_ack_out;
  // dma moves data words only, always to chip select 0 [RQ4]
  assign buf_take = bus_tick && (state_q == ST_IDLE) && !cpu_take && dma_enable_in && buf_valid;
  assign phase_end = bus_tick && (cnt_q == {`PHASE_W{1'b0}});

  // read data arrives from a pin and crosses two flops before use
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      din_meta_q <= {`BUS_W{1'b0}};
      din_sync_q <= {`BUS_W{1'b0}};
    end else begin
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  // transaction engine: setup, strobe, hold, each counted in bus clock ticks;
  // nothing outside can lengthen a phase [RQ3]
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      cnt_q <= {`PHASE_W{1'b0}};
      kind_q <= `KIND_DATA_WR;
      cs_q <= `CS_0;
      from_cpu_q <= 1'b0;
      mode_q <= `MODE_ASYNC_EN;
      tim_q <= {`TIM_W{1'b0}};
      wdata_q <= {`BUS_W{1'b0}};
      cpu_ack_out <= 1'b0;
      cpu_rdata_out <= {`BUS_W{1'b0}};
      busy_out <= 1'b0;
    end else begin
      cpu_ack_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cpu_take) begin
            // port and direction pick the cycle kind [RQ9] [RQ14] [RQ15] [RQ17] [RQ19]
            if (cpu_write_in)
              kind_q <= cpu_addr_port_in ? `KIND_ADDR_WR : `KIND_DATA_WR;
            else
              kind_q <= cpu_addr_port_in ? `KIND_STATUS_RD : `KIND_DATA_RD;
            cs_q <= cpu_cs_eff;
            from_cpu_q <= 1'b1;
            mode_q <= mode_in;
            tim_q <= cpu_tim;
            wdata_q <= cpu_wdata_in; // address or data goes out on the shared bus [RQ12]
            cnt_q <= phase_len(cpu_tim, `TIM_SETUP_LSB);
            state_q <= ST_SETUP;
            busy_out <= 1'b1;
          end else if (buf_take) begin
            kind_q <= `KIND_DATA_WR; // [RQ4]
            cs_q <= `CS_0;
            from_cpu_q <= 1'b0;
            mode_q <= mode_in;
            tim_q <= cs0_timing_in;
            wdata_q <= buf_data;
            cnt_q <= phase_len(cs0_timing_in, `TIM_SETUP_LSB);
            state_q <= ST_SETUP;
            busy_out <= 1'b1;
          end
        end
        ST_SETUP: begin
          if (phase_end) begin
            cnt_q <= phase_len(tim_q, `TIM_STROBE_LSB);
            state_q <= ST_STROBE;
          end else if (bus_tick) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_STROBE: begin
          if (phase_end) begin
            // last strobe tick: the far end has had data valid for a bus cycle
            // [RQ11] [RQ18] [RQ22]
            if (kind_q == `KIND_DATA_RD || kind_q == `KIND_STATUS_RD)
              cpu_rdata_out <= din_sync_q; // [RQ24]
            cnt_q <= phase_len(tim_q, `TIM_HOLD_LSB);
            state_q <= ST_HOLD;
          end else if (bus_tick) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_HOLD: begin
          if (phase_end) begin
            // the answer follows the capture, never precedes it [RQ24]
            cpu_ack_out <= from_cpu_q;
            state_q <= ST_IDLE;
            busy_out <= 1'b0;
          end else if (bus_tick) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  reg active;
  reg strobe;
  reg is_wr;
  reg ale;
  reg dir;
  reg sel0;
  reg sel1;
  reg pclk_d;
  reg hsync_d;
  reg ac_bias_d;
  reg memclk_d;

  // pin functions per mode; all levels active high
  always @* begin
    active = (state_q != ST_IDLE);
    strobe = (state_q == ST_STROBE);
    is_wr = (kind_q == `KIND_ADDR_WR) || (kind_q == `KIND_DATA_WR);
    // latch enable marks address writes and status reads [RQ14] [RQ19] [RQ23]
    ale = active && (kind_q == `KIND_ADDR_WR || kind_q == `KIND_STATUS_RD);
    if (is_pde(mode_q))
      ale = 1'b0; // commands run with latch enable low [RQ9]
    // direction high for reads, low for any write incl. address [RQ13] [RQ17] [RQ10]
    dir = active && !is_wr;
    // select held over the whole cycle [RQ16] [RQ1]
    sel0 = active && (cs_q == `CS_0);
    sel1 = active && (cs_q == `CS_1);
    // strobe pins [RQ7] [RQ15] [RQ21]
    if (is_pde(mode_q)) begin
      pclk_d = 1'b0;
      hsync_d = dir;
    end else if (is_split(mode_q)) begin
      pclk_d = strobe && !is_wr;
      hsync_d = strobe && is_wr;
    end else begin
      pclk_d = strobe;
      hsync_d = dir;
    end
    // select and enable pins [RQ8] [RQ10]
    if (is_pde(mode_q)) begin
      ac_bias_d = strobe && sel0;
      memclk_d = strobe && sel1;
    end else if (is_sync(mode_q)) begin
      ac_bias_d = sel0;
      memclk_d = bus_level; // [RQ25]
    end else begin
      ac_bias_d = sel0;
      memclk_d = sel1;
    end
    // in idle the memory clock still runs in synchronous modes
    if (!active && !is_sync(mode_q))
      memclk_d = 1'b0;
  end

  // every pin leaves through one flop; strobes follow the memory clock pin by one cycle [RQ25]
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pclk_pin_out <= 1'b0;
      hsync_pin_out <= 1'b0;
      vsync_pin_out <= 1'b0;
      ac_bias_pin_out <= 1'b0;
      memory_clk_pin_out <= 1'b0;
      data_out <= {`BUS_W{1'b0}};
      data_oe_n_out <= 1'b1;
      data_buffer_out_en_n_out <= 1'b1;
    end else begin
      pclk_pin_out <= pclk_d;
      hsync_pin_out <= hsync_d;
      vsync_pin_out <= ale; // [RQ8]
      ac_bias_pin_out <= ac_bias_d;
      memory_clk_pin_out <= memclk_d;
      data_out <= wdata_q; // [RQ12]
      // buffer opens only while write data stands on the bus [RQ20]
      data_oe_n_out <= !(active && is_wr);
      data_buffer_out_en_n_out <= !(active && is_wr); // [RQ20]
    end
  end

endmodule // lcd_character_panel_bus_master

//--- panel_bus_chk.sv
`timescale 1ns/100ps
`include "panel_bus_defs.vh"
// pin-level checks of the panel bus master against mode and cpu port
module panel_bus_chk (
  // clock and reset
  input logic ref_clk_in,
  input logic reset_in,
  // configuration
  input logic [`MODE_W-1:0] mode_in,
  input logic [`TIM_W-1:0] cs0_timing_in,
  input logic [`TIM_W-1:0] cs1_timing_in,
  input logic bus_clk_in,
  // cpu port
  input logic cpu_req_in,
  input logic cpu_write_in,
  input logic cpu_addr_port_in,
  input logic cpu_cs_in,
  input logic [`BUS_W-1:0] cpu_wdata_in,
  input logic cpu_ack_out,
  input logic [`BUS_W-1:0] cpu_rdata_out,
  // dma stream
  input logic dma_enable_in,
  input logic dma_valid_in,
  input logic [`BUS_W-1:0] dma_data_in,
  input logic dma_ready_out,
  input logic busy_out,
  // panel pins
  input logic pclk_pin_out,
  input logic hsync_pin_out,
  input logic vsync_pin_out,
  input logic ac_bias_pin_out,
  input logic memory_clk_pin_out,
  input logic data_buffer_out_en_n_out,
  input logic [`BUS_W-1:0] data_in,
  input logic [`BUS_W-1:0] data_out,
  input logic data_oe_n_out
);
  logic en_mode, split_mode, sync_mode, perdev_mode;
  // codes above the per-device one behave as async enable-strobe
  assign en_mode = mode_in == `MODE_ASYNC_EN || mode_in == `MODE_SYNC_EN || mode_in > 3'h4;
  assign split_mode = mode_in == `MODE_ASYNC_SPLIT || mode_in == `MODE_SYNC_SPLIT;
  assign sync_mode = mode_in == `MODE_SYNC_EN || mode_in == `MODE_SYNC_SPLIT;
  assign perdev_mode = mode_in == `MODE_PER_DEVICE;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  oe_pair_a: assert property (data_oe_n_out == data_buffer_out_en_n_out)
    else $error("bus drive and buffer enable differ");
  oe_idle_a: assert property (!busy_out && !$past(busy_out) |-> data_oe_n_out)
    else $error("bus driven while idle");
  ack_pulse_a: assert property (cpu_ack_out |=> !cpu_ack_out)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (cpu_ack_out |-> !busy_out)
    else $error("ack while bus cycle runs");
  dir_read_a: assert property (en_mode && pclk_pin_out
    |-> hsync_pin_out == data_oe_n_out)
    else $error("direction does not follow read or write");
  split_ws_a: assert property (split_mode && hsync_pin_out
    |-> !data_oe_n_out && !pclk_pin_out)
    else $error("write strobe without write data");
  perdev_pins_a: assert property (perdev_mode && busy_out
    |-> !vsync_pin_out && !pclk_pin_out)
    else $error("latch enable or pclk active in per-device mode");
  async_sel_a: assert property (!sync_mode && !perdev_mode && pclk_pin_out
    |-> ac_bias_pin_out != memory_clk_pin_out)
    else $error("strobe without exactly one chip select");
  sync_sel_a: assert property (sync_mode && pclk_pin_out |-> ac_bias_pin_out)
    else $error("sync strobe without chip select 0");
  // the strobe pin rises one cycle after the memory clock pin rose
  sync_edge_a: assert property (sync_mode && $rose(pclk_pin_out)
    |-> $past(memory_clk_pin_out) && !$past(memory_clk_pin_out, 2))
    else $error("strobe not launched from a memory clock rise");
  cycle_bound_a: assert property ($rose(busy_out) |-> ##[30:700] !busy_out)
    else $error("bus cycle length out of range");
  rdata_busy_a: assert property ($changed(cpu_rdata_out) |-> busy_out)
    else $error("read data changed outside a bus cycle");

  cover property (cpu_ack_out && !cpu_write_in);
  cover property (dma_valid_in && !dma_ready_out);
  cover property (perdev_mode && ac_bias_pin_out);
endmodule // panel_bus_chk

//--- panel_model.sv
`timescale 1ns/100ps
// panel with an external address latch on the shared bus
module panel_model #(
  parameter logic [15:0] STATUS = 16'h5a3c // arbitrary status word
) (
  // clock
  input logic ref_clk_in,
  // control as seen by the panel
  input logic ale_in,
  input logic sel_in,
  input logic oe_n_in,
  // shared bus
  input logic [15:0] drive_in,
  output logic [15:0] bus_out,
  // last data word written
  output logic [15:0] last_out
);
  logic [15:0] mem [0:15];
  logic [15:0] addr_q;
  logic [15:0] prev_q;
  logic rd_drv;
  // panel answers for the whole selected read, so data is settled before the strobe drops
  assign rd_drv = sel_in && oe_n_in;
  // a released bus shows the inverse of its last value, not a stale copy
  assign bus_out = !oe_n_in ? drive_in : rd_drv ? (ale_in ? STATUS : mem[addr_q[3:0]]) : ~prev_q;
  // latch the address under latch enable, store data otherwise
  always @(posedge ref_clk_in) begin
    prev_q <= bus_out;
    if (!oe_n_in && sel_in && ale_in)
      addr_q <= drive_in;
    if (!oe_n_in && sel_in && !ale_in) begin
      mem[addr_q[3:0]] <= drive_in;
      last_out <= drive_in;
    end
  end
endmodule // panel_model

//--- testbench.sv
`timescale 1ns/100ps
`include "panel_bus_defs.vh"
module testbench;
  localparam logic [15:0] STAT = 16'h5a3c;
  logic ref_clk_in, reset_in, bus_clk_in, cpu_req_in, cpu_write_in, cpu_addr_port_in, cpu_cs_in;
  logic dma_enable_in, dma_valid_in, cpu_ack_out, dma_ready_out, busy_out, pclk_pin_out;
  logic hsync_pin_out, vsync_pin_out, ac_bias_pin_out, memory_clk_pin_out;
  logic data_buffer_out_en_n_out, data_oe_n_out, sale, spc, shs, scs, smc, soe;
  logic [`MODE_W-1:0] mode_in;
  logic [`TIM_W-1:0] cs0_timing_in, cs1_timing_in;
  logic [`BUS_W-1:0] cpu_wdata_in, cpu_rdata_out, dma_data_in, data_in, data_out, last_w, sd;
  integer mismatches = 0;
  integer num_checks = 0;
  integer cyc;

  lcd_character_panel_bus_master i_lcd_character_panel_bus_master (.ref_clk_in, .reset_in,
    .mode_in, .cs0_timing_in, .cs1_timing_in, .bus_clk_in, .cpu_req_in, .cpu_write_in,
    .cpu_addr_port_in, .cpu_cs_in, .cpu_wdata_in, .cpu_ack_out, .cpu_rdata_out, .dma_enable_in,
    .dma_valid_in, .dma_data_in, .dma_ready_out, .busy_out, .pclk_pin_out, .hsync_pin_out,
    .vsync_pin_out, .ac_bias_pin_out, .memory_clk_pin_out, .data_buffer_out_en_n_out, .data_in,
    .data_out, .data_oe_n_out);
  panel_model #(.STATUS(STAT)) i_panel_model (.ref_clk_in, .ale_in(vsync_pin_out),
    .sel_in(ac_bias_pin_out), .oe_n_in(data_oe_n_out), .drive_in(data_out),
    .bus_out(data_in), .last_out(last_w));

  // 100 MHz reference clock
  initial begin
    ref_clk_in = 0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // bus clock, 125 ns period, phase unrelated to the reference
  initial begin
    bus_clk_in = 0;
    #7.3;
    forever #62.5 bus_clk_in = ~bus_clk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      num_checks++;
      if (seen !== exp) begin
        mismatches++;
        $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // one cpu port access; records which pins were seen active meanwhile
  task automatic cpu_op(input logic w, input logic a, input logic c, input logic [15:0] wd);
    begin
      {sale, spc, shs, scs, smc, soe} = 6'h0;
      sd = 16'h0;
      cpu_write_in = w;
      cpu_addr_port_in = a;
      cpu_cs_in = c;
      cpu_wdata_in = wd;
      cpu_req_in = 1;
      cyc = 0;
      while (cpu_ack_out !== 1'b1 && cyc < 2000) begin
        @(posedge ref_clk_in);
        #1;
        cyc++;
        {sale, spc, shs} = {sale, spc, shs} | {vsync_pin_out, pclk_pin_out, hsync_pin_out};
        {scs, smc} = {scs, smc} | {ac_bias_pin_out, memory_clk_pin_out};
        if (data_oe_n_out === 1'b0) begin
          soe = 1;
          sd = data_out;
        end
      end
      if (cyc >= 2000) begin
        mismatches++;
        give_verdict;
      end
      cpu_req_in = 0;
      @(posedge ref_clk_in);
      #1;
    end
  endtask

  // address write, data write, data read and status read in the four strobe modes
  task automatic t_modes;
    logic [15:0] wd;
    begin
      for (int m = 0; m < 4; m++) begin
        mode_in = m[2:0];
        wd = 16'ha5c0 + m[15:0];
        cpu_op(1, 1, 0, 16'h0003);
        check({sale, scs}, 2'b11);
        check(sd, 16'h0003);
        check(shs, m[0]);
        check(spc, !m[0]);
        check(smc, m[1]);
        cpu_op(1, 0, 0, wd);
        check({sale, scs}, 2'b01);
        check(sd, wd);
        check(shs, m[0]);
        cpu_op(0, 0, 0, 16'h0);
        check(cpu_rdata_out, wd);
        check({sale, spc, soe}, 3'b010);
        check(shs, !m[0]);
        cpu_op(0, 1, 0, 16'h0);
        check(cpu_rdata_out, STAT);
        check({sale, spc, scs, soe}, 4'b1110);
      end
      $display("test modes done");
    end
  endtask

  // second chip select with its own timing, and its absence in sync mode
  task automatic t_cs1;
    begin
      mode_in = `MODE_ASYNC_EN;
      cs1_timing_in = 12'h333;
      cpu_op(1, 0, 1, 16'h1234);
      check({smc, scs}, 2'b10);
      check(cyc > 100, 1);
      cpu_op(1, 0, 0, 16'h4321);
      check(cyc < 60, 1);
      mode_in = `MODE_SYNC_EN;
      cpu_op(1, 0, 1, 16'h5678);
      check(scs, 1);
      check(cyc < 60, 1);
      $display("test chip selects done");
    end
  endtask

  // per-device enable mode: no latch enable, direction and enable 0
  task automatic t_perdev;
    begin
      mode_in = `MODE_PER_DEVICE;
      cpu_op(1, 0, 0, 16'hbeef);
      check({sale, spc, shs, scs}, 4'b0001);
      cpu_op(0, 0, 0, 16'h0);
      check(cpu_rdata_out, 16'hbeef);
      check(shs, 1);
      cpu_op(1, 1, 0, 16'h0007);
      check({sale, scs}, 2'b01);
      cpu_op(1, 0, 1, 16'h2222);
      check({smc, scs}, 2'b10);
      $display("test per-device done");
    end
  endtask

  task automatic wait_last(input logic [15:0] v);
    integer n;
    begin
      n = 0;
      while (last_w !== v && n < 3000) begin
        @(posedge ref_clk_in);
        #1;
        n++;
      end
      check(last_w, v);
      if (n >= 3000)
        give_verdict;
    end
  endtask

  // fill the buffer with the drain held off, then drain it in order
  task automatic t_dma;
    integer k;
    logic r;
    begin
      mode_in = `MODE_ASYNC_EN;
      dma_valid_in = 1;
      k = 0;
      for (int n = 0; n < 8; n++) begin
        dma_data_in = 16'hd000 + k[15:0];
        r = dma_ready_out;
        @(posedge ref_clk_in);
        #1;
        if (r === 1'b1)
          k++;
      end
      dma_valid_in = 0;
      check(k[15:0], 16'h2);
      dma_enable_in = 1;
      wait_last(16'hd000);
      wait_last(16'hd001);
      dma_valid_in = 1;
      dma_data_in = 16'hd002;
      @(posedge ref_clk_in);
      #1;
      dma_valid_in = 0;
      wait_last(16'hd002);
      dma_enable_in = 0;
      $display("test dma done");
    end
  endtask

  // reset, then the scenarios in turn
  initial begin
    reset_in = 1;
    mode_in = 3'h0;
    {cpu_req_in, cpu_write_in, cpu_addr_port_in, cpu_cs_in} = 4'h0;
    {dma_enable_in, dma_valid_in} = 2'h0;
    cs0_timing_in = 12'h000;
    cs1_timing_in = 12'h000;
    cpu_wdata_in = 16'h0;
    dma_data_in = 16'h0;
    repeat (12) @(posedge ref_clk_in);
    #1;
    reset_in = 0;
    @(posedge ref_clk_in);
    #1;
    t_modes;
    t_cs1;
    t_perdev;
    t_dma;
    give_verdict;
  end
endmodule // testbench

bind lcd_character_panel_bus_master panel_bus_chk i_panel_bus_chk (.ref_clk_in, .reset_in,
  .mode_in, .cs0_timing_in, .cs1_timing_in, .bus_clk_in, .cpu_req_in, .cpu_write_in,
  .cpu_addr_port_in, .cpu_cs_in, .cpu_wdata_in, .cpu_ack_out, .cpu_rdata_out, .dma_enable_in,
  .dma_valid_in, .dma_data_in, .dma_ready_out, .busy_out, .pclk_pin_out, .hsync_pin_out,
  .vsync_pin_out, .ac_bias_pin_out, .memory_clk_pin_out, .data_buffer_out_en_n_out, .data_in,
  .data_out, .data_oe_n_out);
